// file: hw/lcd_host_ctrl.sv
// host controller driving a dot-matrix display controller over its parallel 8-bit bus
// Behaviour
// - host sets page and column on page change
// - contrast is two-byte sequence
// - booster is two-byte sequence
// - host never issues test opcodes
// - select low instruction, high data
`timescale 1ns/100ps
`include "lcd_host_defs.svh"
module lcd_host_ctrl #(
  parameter int RESET_LOW_CYCLES = `CNT_RESET_LOW,
  parameter int RESET_WAIT_CYCLES = `CNT_RESET_WAIT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire lcd_host_pkg::sw_req_t sw_req,
  output lcd_host_pkg::lcd_ctl_t lcd_ctl,
  output logic [7:0] sw_rdata,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe,
  input wire logic [7:0] host_data_bus_i
);
  import lcd_host_pkg::*;

  // counts outside the 16-bit counter cannot be served, so they are refused at elaboration
  if (RESET_LOW_CYCLES < 1 || RESET_WAIT_CYCLES < 1 || RESET_LOW_CYCLES > 65535 || RESET_WAIT_CYCLES > 65535) begin : g_bad_counts
    $error("reset counts out of range");
  end

  localparam logic [15:0] SETUP_N = 16'(`CNT_SETUP);
  localparam logic [15:0] STROBE_N = 16'(`CNT_STROBE_LOW);
  localparam logic [15:0] RECOVER_N = 16'(`CNT_CYCLE - `CNT_SETUP - `CNT_STROBE_LOW);

  // --------------------------------------------------------------------------
  // transfer shape
  // --------------------------------------------------------------------------
  // a transfer is cut into three timed phases, each held by the one counter:
  //   setup   - chip select low, register select and data settled, no strobe
  //   strobe  - the active phase, long enough for the slower read case
  //   recover - strobe released, select still low, then everything let go
  // the phase lengths are whole clock cycles rounded up from the pin timings,
  // so a faster sys_clk only lengthens the counts, never shortens a phase.
  //
  // two bus styles share the same phases:
  //   style 0: strobe_a is a low-active read strobe, strobe_b a low-active
  //            write strobe; both idle high.
  //   style 1: strobe_a is a high-active enable that idles low, strobe_b
  //            selects the direction (1 read) and is set at the setup phase.
  // the idle level of strobe_a follows the style in the idle state but not
  // during the device reset pulse, so a style change made while idle leaves
  // an active strobe on the pins with chip select released for one cycle,
  // or for the whole reset pulse when the same control write starts a reset.
  //
  // read data are taken at the end of the strobe phase from the pins after
  // two flip-flops; the strobe phase is longer than the two-cycle latency
  // plus the device access time, which is what makes the capture safe.
  // status reads keep only the upper nibble, the lower one is forced to zero.
  //
  // software sees one slot: a request that meets a busy slot is dropped
  // rather than queued. this keeps the block free of any buffer, at the cost
  // that software has to poll the busy bit between requests.
  // the busy bit also covers the device reset pulse, so software simply
  // waits for it to clear after reset before its first request.
  //
  // two-byte instructions are tracked by one flag; the argument byte is
  // masked to its legal width here, so a stray upper bit from software can
  // never turn an argument into something the device reads as an opcode.
  // opcodes in the factory test group are never put on the pins at all.
  //
  // limitation: nothing here knows the device's own busy time after a soft
  // reset or a mode change; the recover phase covers bus cycle time only.

  // --------------------------------------------------------------------------
  // software side state
  // --------------------------------------------------------------------------
  bus_state_t state;
  logic [15:0] count;
  logic bus_mode; // 0: separate strobes, 1: enable with read/write select
  logic pend_valid;
  logic pend_rd;
  logic pend_rs;
  logic [7:0] pend_data;
  logic second_byte; // next command byte is an argument
  logic illegal_seen;
  logic [7:0] rdata_hold;
  logic [7:0] rx_meta;
  logic [7:0] rx_sync;
  logic start_reset;

  // an opcode in the factory test group is dropped, unless it is an argument
  function automatic logic is_test_op(input logic [7:0] op, input logic arg);
    return !arg && op[7:4] == 4'hF && op != `OP_BOOSTER;
  endfunction

  // opcodes that are followed by one argument byte
  function automatic logic takes_arg(input logic [7:0] op);
    return op == `OP_CONTRAST || op == `OP_BOOSTER;
  endfunction

  wire logic busy = pend_valid || state != ST_IDLE;
  wire logic cmd_wr = sw_req.wr && sw_req.addr == `REG_CMD && !busy;
  wire logic data_wr = sw_req.wr && sw_req.addr == `REG_DATA && !busy;
  wire logic rd_go = sw_req.wr && sw_req.addr == `REG_RDATA && !busy;
  assign start_reset = sw_req.wr && sw_req.addr == `REG_CTRL && sw_req.wdata[`CTRL_RESET_BIT];

  // --------------------------------------------------------------------------
  // software register writes and pending transfer
  // --------------------------------------------------------------------------
  // one pending transfer; requests arriving while busy are dropped and leave no trace in status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_valid <= 1'b0;
      pend_rd <= 1'b0;
      pend_rs <= 1'b0;
      pend_data <= 8'h00;
      second_byte <= 1'b0;
      illegal_seen <= 1'b0;
    end else if (cmd_wr) begin
      if (is_test_op(sw_req.wdata, second_byte)) begin
        illegal_seen <= 1'b1;
      end else begin
        pend_valid <= 1'b1;
        pend_rd <= 1'b0;
        pend_rs <= 1'b0;
        pend_data <= second_byte ? {2'b00, sw_req.wdata[5:0]} & (pend_data == `OP_BOOSTER ? 8'h03 : 8'h3F) : sw_req.wdata;
        second_byte <= !second_byte && takes_arg(sw_req.wdata);
      end
    end else if (data_wr || rd_go) begin
      pend_valid <= 1'b1;
      pend_rd <= rd_go;
      pend_rs <= data_wr ? 1'b1 : sw_req.wdata[0];
      pend_data <= sw_req.wdata;
      second_byte <= 1'b0;
    end else if (state == ST_SETUP) begin
      pend_valid <= 1'b0;
    end
    if (!rst && sw_req.wr && sw_req.addr == `REG_STATUS) begin
      illegal_seen <= 1'b0;
    end
  end

  // bus mode bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_mode <= 1'b0;
    end else if (sw_req.wr && sw_req.addr == `REG_CTRL) begin
      bus_mode <= sw_req.wdata[`CTRL_BUSMODE_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // pin side sequencer
  // --------------------------------------------------------------------------
  // incoming data pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_meta <= 8'h00;
      rx_sync <= 8'h00;
    end else begin
      rx_meta <= host_data_bus_i;
      rx_sync <= rx_meta;
    end
  end

  // timing is held long enough for both bus styles, so one sequence serves both
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_RST_LOW;
      count <= 16'(RESET_LOW_CYCLES);
    end else if (start_reset && state == ST_IDLE) begin
      state <= ST_RST_LOW;
      count <= 16'(RESET_LOW_CYCLES);
    end else if (count > 16'h0001) begin
      count <= count - 16'h0001;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (pend_valid) begin
            state <= ST_SETUP;
            count <= SETUP_N;
          end
        end
        ST_SETUP: begin
          state <= ST_STROBE;
          count <= STROBE_N;
        end
        ST_STROBE: begin
          state <= ST_RECOVER;
          count <= RECOVER_N;
        end
        ST_RECOVER: begin
          state <= ST_IDLE;
          count <= 16'h0000;
        end
        ST_RST_LOW: begin
          state <= ST_RST_WAIT;
          count <= 16'(RESET_WAIT_CYCLES);
        end
        ST_RST_WAIT: begin
          state <= ST_IDLE;
          count <= 16'h0000;
        end
        default: begin
          state <= ST_IDLE;
          count <= 16'h0000;
        end
      endcase
    end
  end

  // pin drive; read data is caught at the end of the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lcd_ctl <= '{register_select: 1'b0, chip_select_n: 1'b1, strobe_a: 1'b1, strobe_b: 1'b1, reset_n: 1'b0};
      host_data_bus_o <= 8'h00;
      host_data_bus_oe <= 1'b0;
      rdata_hold <= 8'h00;
    end else begin
      lcd_ctl.reset_n <= !(state == ST_RST_LOW && count > 16'h0001);
      if (state == ST_IDLE && pend_valid && count <= 16'h0001) begin
        lcd_ctl.register_select <= pend_rs;
        lcd_ctl.chip_select_n <= 1'b0;
        host_data_bus_o <= pend_data;
        host_data_bus_oe <= !pend_rd;
        lcd_ctl.strobe_b <= bus_mode ? pend_rd : 1'b1;
      end else if (state == ST_SETUP && count <= 16'h0001) begin
        if (bus_mode) begin
          lcd_ctl.strobe_a <= 1'b1;
        end else if (pend_rd) begin
          lcd_ctl.strobe_a <= 1'b0;
        end else begin
          lcd_ctl.strobe_b <= 1'b0;
        end
        if (!bus_mode) begin
          lcd_ctl.strobe_a <= !pend_rd;
        end
      end else if (state == ST_STROBE && count <= 16'h0001) begin
        lcd_ctl.strobe_a <= !bus_mode;
        lcd_ctl.strobe_b <= !bus_mode || lcd_ctl.strobe_b;
        if (!host_data_bus_oe) begin
          rdata_hold <= lcd_ctl.register_select ? rx_sync : {rx_sync[7:4], 4'h0};
        end
      end else if (state == ST_RECOVER && count <= 16'h0001) begin
        lcd_ctl.chip_select_n <= 1'b1;
        host_data_bus_oe <= 1'b0;
        lcd_ctl.strobe_a <= !bus_mode;
        lcd_ctl.strobe_b <= 1'b1;
      end else if (state == ST_IDLE) begin
        // idle enable level follows the style a cycle later; a style change written with or during a reset leaves it active through the pulse
        lcd_ctl.strobe_a <= !bus_mode;
      end
    end
  end

  // --------------------------------------------------------------------------
  // software read port
  // --------------------------------------------------------------------------
  // read data stand in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_rdata <= 8'h00;
    end else if (sw_req.rd) begin
      unique case (sw_req.addr)
        `REG_CTRL: sw_rdata <= {6'h00, bus_mode, 1'b0};
        `REG_STATUS: sw_rdata <= {5'h00, illegal_seen, second_byte, busy};
        `REG_RDATA: sw_rdata <= rdata_hold;
        default: sw_rdata <= 8'h00;
      endcase
    end else begin
      sw_rdata <= 8'h00;
    end
  end
endmodule

// file: hw/lcd_host_defs.svh
// timing counts, opcodes and register offsets of the dot-matrix display host controller
`ifndef LCD_HOST_DEFS_SVH
`define LCD_HOST_DEFS_SVH
`define CLK_PERIOD_NS 25
`define T_RESET_LOW_NS 1000
`define T_RESET_WAIT_NS 1000
`define T_CYCLE_NS 240
`define T_STROBE_LOW_NS 140
`define T_SETUP_NS 40
`define CNT_RESET_LOW ((`T_RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_RESET_WAIT ((`T_RESET_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_STROBE_LOW ((`T_STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_SETUP ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_CYCLE ((`T_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_DATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
`define CTRL_RESET_BIT 0
`define CTRL_BUSMODE_BIT 1
`define OP_DISPLAY_ON 8'hAF
`define OP_CONTRAST 8'h81
`define OP_BOOSTER 8'hF8
`define OP_RMW 8'hE0
`define OP_RMW_END 8'hEE
`define OP_SOFT_RESET 8'hE2
`define OP_NOP 8'hE3
`define COL_LAST 8'h83
`define PAGE_ICON 4'h8
`endif

// file: hw/lcd_host_pkg.sv
// types shared by the dot-matrix display host controller
package lcd_host_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sw_req_t;
  typedef struct packed {
    logic register_select;
    logic chip_select_n;
    logic strobe_a;
    logic strobe_b;
    logic reset_n;
  } lcd_ctl_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_RECOVER = 3'b011,
    ST_RST_LOW = 3'b100,
    ST_RST_WAIT = 3'b101
  } bus_state_t;
endpackage

// file: tb/lcd_host_properties.sv
// pin protocol checker of the display host controller
`timescale 1ns/100ps
module lcd_host_chk
  import lcd_host_pkg::*;
#(
  parameter int RESET_LOW_CYCLES = 2,
  parameter int RESET_WAIT_CYCLES = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire lcd_host_pkg::sw_req_t sw_req,
  input wire lcd_host_pkg::lcd_ctl_t lcd_ctl,
  input wire logic [7:0] sw_rdata,
  input wire logic [7:0] host_data_bus_o,
  input wire logic host_data_bus_oe,
  input wire logic [7:0] host_data_bus_i
);
  // ----
  // aliases, mode 0 strobes (low active)
  // ----
  wire cs = !lcd_ctl.chip_select_n;
  wire rdn = lcd_ctl.strobe_a;
  wire wrn = lcd_ctl.strobe_b;
  wire oe = host_data_bus_oe;
  logic mode;
  logic mode_d;
  // bus style as software set it, and one cycle later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode <= 1'b0;
      mode_d <= 1'b0;
    end else begin
      if (sw_req.wr && sw_req.addr == 4'h0) begin
        mode <= sw_req.wdata[1];
      end
      mode_d <= mode;
    end
  end
  // a style counts as settled once it has stood for a cycle
  wire m0 = !mode && !mode_d;
  wire m1 = mode && mode_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence wr_go;
    $fell(wrn);
  endsequence
  sequence rd_go;
    $fell(rdn);
  endsequence
  sequence en_go;
    $rose(rdn);
  endsequence
  a_rst_quiet: assert property (disable iff (1'b0) rst |=> !lcd_ctl.reset_n && !cs && rdn && wrn && !oe)
    else $error("pins active during reset");
  a_rdata_zero: assert property (!sw_req.rd |=> sw_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_drive_sel: assert property ((oe || (m0 && (!rdn || !wrn)) || (m1 && rdn)) |-> cs)
    else $error("bus activity while deselected");
  a_wr_setup: assert property (m0 ##0 wr_go |-> oe && $past(oe, 2))
    else $error("write data not set up");
  a_rd_width: assert property (m0 ##0 rd_go |-> !rdn [*6])
    else $error("read strobe too short");
  a_wr_width: assert property (m0 ##0 wr_go |-> !wrn [*4])
    else $error("write strobe too short");
  a_en_width: assert property (m1 ##0 en_go |-> rdn [*6])
    else $error("enable pulse too short");
  a_en_setup: assert property (m1 ##0 en_go |-> cs && $past(cs, 2))
    else $error("enable without select setup");
  a_data_hold: assert property (m0 && !wrn && !$past(wrn) |-> $stable(host_data_bus_o) && !(!rdn))
    else $error("write data moved under strobe");
  a_sel_hold: assert property (cs && $past(cs) |-> $stable(lcd_ctl.register_select))
    else $error("select moved in transfer");
  a_no_test: assert property (m0 && $rose(wrn) && !lcd_ctl.register_select && $past(host_data_bus_o[7:4]) == 4'hF
    |-> $past(host_data_bus_o) == 8'hF8)
    else $error("test opcode sent");
endmodule

// file: tb/lcd_dev_model.sv
// display controller model behind the parallel bus
`timescale 1ns/100ps
module lcd_dev_model
  import lcd_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic mode,
  input wire lcd_host_pkg::lcd_ctl_t ctl,
  input wire logic [7:0] hd_o,
  input wire logic hd_oe,
  output logic [7:0] bus
);
  logic [7:0] mem [0:8][0:131]; // no panel readout here
  logic [3:0] pg;
  logic [7:0] col, wb, last;
  logic [5:0] sl, vol; // vol index is 63 minus vol
  logic [2:0] pwr, rr;
  logic [1:0] bst;
  logic adc, on, inv, aon, bias, rmw, common_line, awake, a81, af8, pw, pr, wrs;
  wire sel = !ctl.chip_select_n;
  // style 1: high enable with direction select, style 0: two low strobes
  wire rd = sel && (mode ? ctl.strobe_a && ctl.strobe_b : !ctl.strobe_a);
  wire wr = sel && (mode ? ctl.strobe_a && !ctl.strobe_b : !ctl.strobe_b);
  wire [7:0] dq = ctl.register_select ? mem[pg][col] : {1'b0, adc, on, 5'h00};
  // a released bus toggles so a stale byte never passes for data
  assign bus = hd_oe ? hd_o : (rd ? dq : ~last);
  task automatic init();
    {pg, col, sl, vol, pwr, rr, bst, adc, on, inv, aon, bias, rmw, common_line, awake, a81, af8} <= '0;
  endtask
  always @(posedge sys_clk) begin
    last <= bus;
    pw <= wr;
    pr <= rd;
    if (wr) begin
      wb <= hd_o;
      wrs <= ctl.register_select;
    end
    if (!ctl.reset_n) init();
    else if (pr && !rd && ctl.register_select && !rmw && col != 8'h83) col <= col + 8'h01;
    else if (pw && !wr) begin
      if (wrs) begin
        mem[pg][col] <= pg == 4'h8 ? {7'h00, wb[0]} : wb;
        if (col != 8'h83) col <= col + 8'h01;
      end else if (a81) {a81, vol} <= {1'b0, wb[5:0]};
      else if (af8) {af8, bst} <= {1'b0, wb[1:0]};
      else casez (wb)
        8'b0000????: col[3:0] <= wb[3:0];
        8'b0001????: col[7:4] <= wb[3:0];
        8'b00100???: rr <= wb[2:0];
        8'b00101???: pwr <= wb[2:0];
        8'b01??????: sl <= wb[5:0];
        8'b1011????: pg <= wb[3:0];
        8'b1010000?: adc <= wb[0];
        8'b1010001?: bias <= wb[0];
        8'b1010010?: aon <= wb[0];
        8'b1010011?: inv <= wb[0];
        8'b1010110?: awake <= wb[0];
        8'b1010111?: on <= wb[0];
        8'b1100????: common_line <= wb[3];
        8'h81: a81 <= 1'b1;
        8'hE0: rmw <= 1'b1;
        8'hEE: rmw <= 1'b0;
        8'hE2: init();
        8'hF8: af8 <= 1'b1;
        default: ; // E3 idles
      endcase
    end
  end
endmodule

// file: tb/lcd_host_ctrl_tb.sv
// self-checking bench of the display host controller
`timescale 1ns/100ps
module lcd_host_ctrl_tb;
  import lcd_host_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  sw_req_t sw_req = '0;
  lcd_ctl_t lcd_ctl;
  logic [7:0] sw_rdata, hd_o, bus, v, d0, d1, d2;
  logic hd_oe;
  logic mode1 = 1'b0;
  logic [31:0] seed = 32'hB8F57841;
  logic [7:0] ops [8] = '{8'hA7, 8'hA5, 8'hA3, 8'hC8, 8'h2D, 8'h25, 8'hAD, 8'h7F};
  int n_fail = 0;
  int tests_run = 0;
  lcd_host_ctrl #(.RESET_LOW_CYCLES(2), .RESET_WAIT_CYCLES(2)) dut (.sys_clk(sys_clk), .rst(rst),
    .sw_req(sw_req), .lcd_ctl(lcd_ctl), .sw_rdata(sw_rdata), .host_data_bus_o(hd_o),
    .host_data_bus_oe(hd_oe), .host_data_bus_i(bus));
  lcd_dev_model m (.sys_clk(sys_clk), .mode(mode1), .ctl(lcd_ctl), .hd_o(hd_o), .hd_oe(hd_oe), .bus(bus));
  initial forever #12.5 sys_clk = ~sys_clk;
  // ----
  // helpers
  // ----
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] st(input logic a, input logic o);
    return {1'b0, a, o, 5'h00};
  endfunction
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    sw_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    sw_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    sw_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    sw_req.rd <= 1'b0;
    @(posedge sys_clk);
    d = sw_rdata;
  endtask
  // polls busy, a bounded wait so a stuck transfer cannot hang the run
  task automatic idle();
    for (int i = 0; i < 100; i++) begin
      rd(4'h3, v);
      if (v[0] === 1'b0) return;
    end
    n_fail++;
  endtask
  task automatic cmd(input logic [7:0] b);
    wr(4'h1, b);
    idle();
  endtask
  task automatic dat(input logic [7:0] b);
    wr(4'h2, b);
    idle();
  endtask
  task automatic drd(input logic rs, output logic [7:0] d);
    wr(4'h4, {7'h00, rs});
    idle();
    rd(4'h4, d);
  endtask
  task automatic at(input logic [3:0] p, input logic [7:0] c);
    cmd({4'hB, p});
    cmd({4'h1, c[7:4]});
    cmd({4'h0, c[3:0]});
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    idle();
    d0 = rnd();
    d1 = rnd();
    d2 = rnd();
    at(4'h0, 8'h82);
    dat(d0);
    dat(d1);
    dat(d2);
    cmd(8'h02);
    drd(1'b1, v);
    chk("col82", v, d0);
    drd(1'b1, v);
    chk("col83", v, d2);
    drd(1'b1, v);
    chk("col83 held", v, d2);
    at(4'h8, 8'h00);
    dat(d1);
    cmd(8'h00);
    drd(1'b1, v);
    chk("icon", v, {7'h00, d1[0]});
    at(4'h1, 8'h05);
    dat(d0);
    dat(d1);
    cmd(8'h05);
    cmd(8'hE0);
    drd(1'b1, v);
    drd(1'b1, v);
    chk("rmw read", v, d0);
    dat(d2);
    drd(1'b1, v);
    chk("rmw write", v, d1);
    cmd(8'hEE);
    cmd(8'hAF);
    cmd(8'hA1);
    cmd(8'hE3);
    drd(1'b0, v);
    chk("status", v, st(1'b1, 1'b1));
    cmd(8'hE2);
    drd(1'b0, v);
    chk("soft reset", v, st(1'b0, 1'b0));
    at(4'h1, 8'h05);
    drd(1'b1, v);
    chk("kept", v, d2);
    foreach (ops[i]) cmd(ops[i]);
    chk("modes", {m.inv, m.aon, m.bias, m.common_line, m.awake, m.pwr}, 8'hFD);
    chk("ratio line", {m.rr, m.sl[4:0]}, 8'hBF);
    cmd(8'h81);
    rd(4'h3, v);
    chk("arg wait", {7'h00, v[1]}, 8'h01);
    cmd(8'hFF);
    chk("contrast", {2'b00, m.vol}, 8'h3F);
    for (int i = 0; i < 4; i++) begin
      cmd(8'hF8);
      cmd({d0[5:0], i[1:0]});
      chk("boost", {6'h00, m.bst}, i[7:0]);
    end
    wr(4'h1, {4'hF, d1[3:1], 1'b1});
    idle();
    rd(4'h3, v);
    chk("refused", {7'h00, v[2]}, 8'h01);
    wr(4'h3, 8'h00);
    rd(4'h3, v);
    chk("cleared", {7'h00, v[2]}, 8'h00);
    cmd(8'hA1);
    wr(4'h0, 8'h01);
    idle();
    drd(1'b0, v);
    chk("pin reset", v, st(1'b0, 1'b0));
    for (int j = 0; j < 2; j++) begin
      mode1 <= j[0];
      wr(4'h0, {6'h00, j[0], 1'b0});
      for (int i = 0; i < 8; i++) begin
        d0 = rnd();
        d1 = rnd() % 8'h84;
        at({1'b0, d0[2:0]}, d1);
        dat(d0);
        at({1'b0, d0[2:0]}, d1);
        drd(1'b1, v);
        chk("random", v, d0);
      end
    end
    conclude();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule
bind lcd_host_ctrl lcd_host_chk #(.RESET_LOW_CYCLES(RESET_LOW_CYCLES), .RESET_WAIT_CYCLES(RESET_WAIT_CYCLES)) chk_i (
  .sys_clk(sys_clk), .rst(rst), .sw_req(sw_req), .lcd_ctl(lcd_ctl), .sw_rdata(sw_rdata),
  .host_data_bus_o(host_data_bus_o), .host_data_bus_oe(host_data_bus_oe), .host_data_bus_i(host_data_bus_i));
